// *** hw/smbbt_pkg.sv ***
`default_nettype none
package smbbt_pkg;
   // ************
   // register map
   // ************
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STAT = 8'h04;
   localparam logic [7:0] ADR_SHIFT = 8'h08;
   localparam logic [7:0] ADR_OWN = 8'h0C;
   localparam logic [7:0] ADR_ISTAT = 8'h10;
   localparam logic [7:0] ADR_IMASK = 8'h14;
   // control bits (start, stop, release are write pulses)
   localparam int B_START = 0;
   localparam int B_STOP = 1;
   localparam int B_WREL = 2;
   localparam int B_WTIM = 3;
   localparam int B_SPIE = 4;
   localparam int B_STIE = 5;
   localparam int B_ACKE = 6;
   localparam int B_RD = 7;
   localparam logic [7:0] CTRL_KEEP = 8'hF8;
   // bus status bits
   localparam int S_BUSY = 0;
   localparam int S_MST = 1;
   localparam int S_ACKD = 2;
   localparam int S_TRC = 3;
   localparam int S_EXC = 4;
   localparam int S_SLV = 5;
   localparam int S_WAIT = 6;
   // interrupt status bits
   localparam int I_START = 0;
   localparam int I_XFER = 1;
   localparam int I_STOP = 2;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [6:0] OWN_RST = 7'h10;
   localparam logic [7:0] SHIFT_RST = 8'hFF;
   localparam logic [2:0] IRQ_RST = 3'h0;
   localparam logic [2:0] PIN_RST = 3'h7;
   // bit counter marks
   localparam logic [3:0] CNT_7TH = 4'h6;
   localparam logic [3:0] CNT_8TH = 4'h7;
   localparam logic [3:0] CNT_ACK = 4'h8;
   // extension code prefixes
   localparam logic [3:0] EXT_LO = 4'h0;
   localparam logic [3:0] EXT_HI = 4'hF;
   // timing: half serial clock period, least time
   localparam int CLK_NS = 8;
   localparam int T_HALF_NS = 5000;
   localparam int HALF_CYC = (T_HALF_NS + CLK_NS - 1) / CLK_NS;
   // master sequencer
   typedef enum logic [1:0] {
      MS_IDLE = 2'b00,
      MS_START = 2'b01,
      MS_RUN = 2'b10,
      MS_STOP = 2'b11
   } smbbt_mst_t;
endpackage
`default_nettype wire

// *** hw/smbbt_line_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// filtered view of the two bus lines
interface smbbt_line_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
   modport snk (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface
`default_nettype wire

// *** hw/smbbt_pins.sv ***
`timescale 1ns/100ps
`default_nettype none
module smbbt_pins (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // raw line levels
   input wire logic scl_i,
   input wire logic sda_i,
   // filtered lines and events
   smbbt_line_if.src ln
);
   typedef struct packed {
      logic [2:0] scl_sy;
      logic [2:0] sda_sy;
      logic scl;
      logic sda;
      logic rise;
      logic fall;
      logic st;
      logic sp;
   } smbbt_pin_st_t;

   smbbt_pin_st_t s;
   smbbt_pin_st_t next_s;

   // ****************
   // filter and edges
   // ****************
   // a level counts once second and third stage agree
   always_comb begin
      next_s = s;
      next_s.scl_sy = {s.scl_sy[1:0], scl_i};
      next_s.sda_sy = {s.sda_sy[1:0], sda_i};
      if (s.scl_sy[1] == s.scl_sy[2]) begin
         next_s.scl = s.scl_sy[2];
      end
      if (s.sda_sy[1] == s.sda_sy[2]) begin
         next_s.sda = s.sda_sy[2];
      end
      next_s.rise = next_s.scl & ~s.scl;
      next_s.fall = ~next_s.scl & s.scl;
      // data moving while clock stays high marks start or stop
      next_s.st = s.scl & next_s.scl & s.sda & ~next_s.sda;
      next_s.sp = s.scl & next_s.scl & ~s.sda & next_s.sda;
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '{scl_sy: smbbt_pkg::PIN_RST, sda_sy: smbbt_pkg::PIN_RST,
                scl: 1'b1, sda: 1'b1, default: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   // line view
   assign ln.scl = s.scl;
   assign ln.sda = s.sda;
   assign ln.scl_rise = s.rise;
   assign ln.scl_fall = s.fall;
   assign ln.start_det = s.st;
   assign ln.stop_det = s.sp;
endmodule
`default_nettype wire

// *** hw/smbbt_core.sv ***
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module smbbt_core #(
   parameter int HALF_CYC = smbbt_pkg::HALF_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // interrupt
   output logic irq_o,
   // serial clock line
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   // serial data line
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o
);
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      logic irq;
      logic [7:0] ctrl;
      logic [6:0] own;
      logic [2:0] ist;
      logic [2:0] imsk;
      logic [7:0] shift;
      logic latch;
      logic rx;
      logic armed;
      logic [3:0] cnt;
      logic first;
      logic busy;
      logic slv;
      logic ext;
      logic trc;
      logic ackd;
      logic ackdrv;
      logic waiting;
      smbbt_pkg::smbbt_mst_t mst;
      logic mscl;
      logic msda;
      logic [15:0] div;
      logic scl_oe;
      logic sda_oe;
   } smbbt_core_st_t;

   smbbt_core_st_t s;
   smbbt_core_st_t next_s;
   smbbt_line_if ln ();

   logic wb_hit;
   logic wr;
   logic [7:0] wdat;
   logic [7:0] ofs;
   logic tick;
   logic vfall;
   logic mact;
   logic [7:0] byte_in;
   logic match_now;
   logic ext_now;
   logic part_now;
   logic rcv_now;
   logic waitpt;

   // word address of a byte address
   function automatic logic [7:0] reg_ofs(input logic [7:0] a);
      return {a[7:2], 2'b00};
   endfunction

   // ************
   // line filter
   // ************
   smbbt_pins u_pins (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .ln(ln.src)
   );

   // ****************
   // shared decodes
   // ****************
   always_comb begin
      wb_hit = wb_cyc_i & wb_stb_i & ~s.ack;
      wr = wb_hit & wb_we_i & wb_sel_i[0];
      wdat = wb_dat_i[7:0];
      ofs = reg_ofs(wb_adr_i);
      tick = (s.div == 16'(HALF_CYC - 1));
      vfall = ln.scl_fall & s.armed & s.busy; // falls after a captured bit only
      mact = (s.mst != smbbt_pkg::MS_IDLE);
      byte_in = {s.shift[6:0], s.rx};
      match_now = (byte_in[7:1] == s.own);
      ext_now = (byte_in[7:4] == smbbt_pkg::EXT_LO) | (byte_in[7:4] == smbbt_pkg::EXT_HI);
      part_now = mact | s.slv | (s.first & (match_now | ext_now));
      rcv_now = s.first ? (~mact & (match_now | ext_now)) : ((mact | s.slv) & ~s.trc);
      waitpt = s.ctrl[smbbt_pkg::B_WTIM] ? (s.cnt == smbbt_pkg::CNT_ACK)
                                          : (s.cnt == smbbt_pkg::CNT_8TH);
   end

   // ****************
   // next state
   // ****************
   always_comb begin
      next_s = s;
      // register bus: one-cycle ack, reads from current state
      next_s.ack = wb_hit;
      next_s.dat = 32'h0000_0000;
      if (wb_hit && !wb_we_i) begin
         case (ofs)
            smbbt_pkg::ADR_CTRL: next_s.dat[7:0] = s.ctrl;
            smbbt_pkg::ADR_STAT: begin
               next_s.dat[smbbt_pkg::S_BUSY] = s.busy;
               next_s.dat[smbbt_pkg::S_MST] = mact;
               next_s.dat[smbbt_pkg::S_ACKD] = s.ackd;
               next_s.dat[smbbt_pkg::S_TRC] = s.trc;
               next_s.dat[smbbt_pkg::S_EXC] = s.ext;
               next_s.dat[smbbt_pkg::S_SLV] = s.slv;
               next_s.dat[smbbt_pkg::S_WAIT] = s.waiting;
            end
            smbbt_pkg::ADR_SHIFT: next_s.dat[7:0] = s.shift;
            smbbt_pkg::ADR_OWN: next_s.dat[6:0] = s.own;
            smbbt_pkg::ADR_ISTAT: next_s.dat[2:0] = s.ist;
            smbbt_pkg::ADR_IMASK: next_s.dat[2:0] = s.imsk;
            default: next_s.dat = 32'h0000_0000;
         endcase
      end
      // register writes; hardware sets below win over these clears
      if (wr) begin
         case (ofs)
            smbbt_pkg::ADR_CTRL: begin
               next_s.ctrl = wdat & smbbt_pkg::CTRL_KEEP;
               if (wdat[smbbt_pkg::B_WREL]) begin
                  next_s.waiting = 1'b0;
                  if (s.mst == smbbt_pkg::MS_RUN) begin
                     next_s.msda = 1'b0;
                  end
               end
            end
            smbbt_pkg::ADR_SHIFT: begin
               next_s.shift = wdat;
               if (s.first && s.mst == smbbt_pkg::MS_RUN) begin
                  next_s.shift[0] = s.ctrl[smbbt_pkg::B_RD];
               end
               if (s.cnt == 4'h0) begin
                  next_s.latch = wdat[7];
               end
               next_s.waiting = 1'b0;
               if (s.mst == smbbt_pkg::MS_RUN) begin
                  next_s.msda = 1'b0;
               end
            end
            smbbt_pkg::ADR_OWN: next_s.own = wdat[6:0];
            smbbt_pkg::ADR_ISTAT: next_s.ist = s.ist & ~wdat[2:0];
            smbbt_pkg::ADR_IMASK: next_s.imsk = wdat[2:0];
            default: next_s.own = s.own;
         endcase
      end
      // master sequencer with its half-period divider
      next_s.div = (!mact || tick) ? 16'h0000 : s.div + 16'h0001;
      case (s.mst)
         smbbt_pkg::MS_IDLE: begin
            if (wr && ofs == smbbt_pkg::ADR_CTRL && wdat[smbbt_pkg::B_START] && !s.busy) begin
               next_s.mst = smbbt_pkg::MS_START;
               next_s.msda = 1'b1;
            end
         end
         smbbt_pkg::MS_START: begin
            // clock low, then wait for the address in the shift register
            if (tick) begin
               next_s.mst = smbbt_pkg::MS_RUN;
               next_s.mscl = 1'b1;
               next_s.waiting = 1'b1;
               next_s.trc = 1'b1;
            end
         end
         smbbt_pkg::MS_RUN: begin
            if (wr && ofs == smbbt_pkg::ADR_CTRL && wdat[smbbt_pkg::B_STOP]
                && s.waiting && s.mscl) begin
               next_s.mst = smbbt_pkg::MS_STOP;
               next_s.msda = 1'b1;
               next_s.waiting = 1'b0;
            end else if (tick && !s.waiting) begin
               if (s.mscl) begin
                  next_s.mscl = 1'b0;
               end else if (ln.scl) begin
                  next_s.mscl = 1'b1; // low phase starts only after a high one
               end
            end
         end
         smbbt_pkg::MS_STOP: begin
            if (tick) begin
               if (s.mscl) begin
                  next_s.mscl = 1'b0;
               end else if (ln.scl) begin
                  next_s.msda = 1'b0;
                  next_s.mst = smbbt_pkg::MS_IDLE;
               end
            end
         end
         default: next_s.mst = smbbt_pkg::MS_IDLE;
      endcase
      // start condition opens a new address byte
      if (ln.start_det) begin
         next_s.busy = 1'b1;
         next_s.cnt = 4'h0;
         next_s.armed = 1'b0;
         next_s.first = 1'b1;
         next_s.slv = 1'b0;
         next_s.ext = 1'b0;
         next_s.latch = 1'b1;
         next_s.ackdrv = 1'b0;
         if (s.ctrl[smbbt_pkg::B_STIE]) begin
            next_s.ist[smbbt_pkg::I_START] = 1'b1;
         end
      end
      // capture data on the rising clock
      if (ln.scl_rise && s.busy) begin
         next_s.rx = ln.sda;
         next_s.armed = 1'b1;
         if (s.cnt == smbbt_pkg::CNT_ACK) begin
            next_s.ackd = ~ln.sda;
         end
      end
      // advance on the falling clock
      if (vfall) begin
         next_s.armed = 1'b0;
         if (s.cnt == smbbt_pkg::CNT_ACK) begin
            // ninth fall: an acknowledged transmitter with an eighth-clock wait presents
            // its next msb; otherwise free data so a refused byte lets a stop through
            next_s.cnt = 4'h0;
            next_s.ackdrv = 1'b0;
            next_s.latch = (s.trc && s.ackd && !s.ctrl[smbbt_pkg::B_WTIM]) ? s.shift[7] : 1'b1;
         end else begin
            next_s.shift = byte_in;
            next_s.latch = s.shift[6];
            next_s.cnt = s.cnt + 4'h1;
         end
         if (s.cnt == smbbt_pkg::CNT_8TH) begin
            // eighth fall: free the line for the acknowledge bit
            next_s.latch = 1'b1;
            next_s.ackdrv = s.ctrl[smbbt_pkg::B_ACKE] & rcv_now;
            if (s.first) begin
               next_s.first = 1'b0;
               if (mact) begin
                  next_s.trc = ~s.ctrl[smbbt_pkg::B_RD];
               end else begin
                  next_s.ext = ext_now;
                  next_s.slv = match_now | ext_now;
                  next_s.trc = byte_in[0];
               end
            end
         end
         if (waitpt && part_now) begin
            next_s.waiting = 1'b1;
            next_s.ist[smbbt_pkg::I_XFER] = 1'b1;
         end
      end
      // stop condition ends the transfer
      if (ln.stop_det) begin
         next_s.busy = 1'b0;
         next_s.slv = 1'b0;
         next_s.waiting = 1'b0;
         next_s.ackdrv = 1'b0;
         next_s.latch = 1'b1;
         next_s.mst = smbbt_pkg::MS_IDLE;
         next_s.mscl = 1'b0;
         next_s.msda = 1'b0;
         if (s.ctrl[smbbt_pkg::B_SPIE]) begin
            next_s.ist[smbbt_pkg::I_STOP] = 1'b1;
         end
      end
      // registered pin drives and interrupt level
      next_s.scl_oe = next_s.mscl | next_s.waiting;
      next_s.sda_oe = next_s.msda | next_s.ackdrv
                      | ((next_s.mst != smbbt_pkg::MS_IDLE | next_s.slv) & ~next_s.latch);
      next_s.irq = |(next_s.ist & next_s.imsk);
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '{ctrl: smbbt_pkg::CTRL_RST, own: smbbt_pkg::OWN_RST,
                ist: smbbt_pkg::IRQ_RST, imsk: smbbt_pkg::IRQ_RST,
                shift: smbbt_pkg::SHIFT_RST, latch: 1'b1,
                mst: smbbt_pkg::MS_IDLE, default: '0};
      end else begin
         s <= next_s;
      end
   end

   // outputs from flops, line levels tied to zero; lines are only ever pulled low
   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.dat;
   assign irq_o = s.irq;
   assign scl_oe_o = s.scl_oe;
   assign sda_oe_o = s.sda_oe;
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;

   // ****************
   // assertions
   // ****************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_master_addr_wait:
   assert property (s.mst == smbbt_pkg::MS_START && tick && !ln.stop_det
                    |=> s.waiting && scl_oe_o ##1 scl_oe_o)
      else $error("master did not hold for the address after start");

   a_dir_bit_out:
   assert property (s.mst == smbbt_pkg::MS_RUN && s.first && vfall
                    && s.cnt == smbbt_pkg::CNT_7TH && !ln.stop_det
                    |=> s.latch == $past(s.ctrl[smbbt_pkg::B_RD]))
      else $error("direction bit not driven after address");

   a_shift_msb_first:
   assert property (vfall && s.cnt < smbbt_pkg::CNT_8TH && !ln.stop_det && !ln.start_det
                    |=> s.latch == $past(s.shift[6]))
      else $error("output latch did not take the next msb");

   a_rise_capture:
   assert property (ln.scl_rise && s.busy |=> s.rx == $past(ln.sda))
      else $error("data not captured on rising clock");

   a_start_irq_gate:
   assert property (ln.start_det |=> s.ist[smbbt_pkg::I_START]
                    == ($past(s.ctrl[smbbt_pkg::B_STIE]) | $past(s.ist[smbbt_pkg::I_START])))
      else $error("start interrupt ignores its enable");

   a_addr_irq_gate:
   assert property (vfall && s.first && !mact && !match_now && !ext_now
                    && !s.ist[smbbt_pkg::I_XFER] |=> !s.ist[smbbt_pkg::I_XFER])
      else $error("address interrupt without match or extension code");

   a_stop_irq_gate:
   assert property (ln.stop_det |=> s.ist[smbbt_pkg::I_STOP]
                    == ($past(s.ctrl[smbbt_pkg::B_SPIE]) | $past(s.ist[smbbt_pkg::I_STOP])))
      else $error("stop interrupt ignores its enable");

   a_wait_release:
   assert property (s.waiting && wr && ofs == smbbt_pkg::ADR_SHIFT && !vfall
                    && s.mst != smbbt_pkg::MS_START |=> !s.waiting ##1 !s.waiting || vfall)
      else $error("shift write did not release the wait");

   a_wait_ninth:
   assert property (vfall && s.cnt == smbbt_pkg::CNT_ACK && s.ctrl[smbbt_pkg::B_WTIM]
                    && part_now && !ln.stop_det |=> s.waiting && s.ist[smbbt_pkg::I_XFER])
      else $error("no wait at ninth clock fall");

   a_wait_holds_clock:
   assert property (s.waiting ##1 s.waiting |-> scl_oe_o && $stable(scl_oe_o))
      else $error("clock line released during wait");
endmodule
`default_nettype wire

// *** hw/smbbt_top_note.sv ***
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// *** bench/smbbt_peer.sv ***
`timescale 1ns/100ps
`default_nettype none
// behavioural far-side peer on the two lines: bus master, or addressed slave
module smbbt_peer (
   // wired line levels
   input wire logic scl_i,
   input wire logic sda_i,
   // pull-downs, high = pull the line low
   output logic scl_oe_o,
   output logic sda_oe_o
);
   // half period of the 80 ns link clock
   localparam int HALF_NS = 40;

   // both lines released at time zero, pull-ups give high
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end

   // ****************
   // master behaviour
   // ****************
   // start: data falls while the clock is high, then the clock goes low
   task automatic start_cond();
      sda_oe_o = 1'b1;
      #HALF_NS;
      scl_oe_o = 1'b1;
      #HALF_NS;
   endtask

   // nine clocks; a one in tx releases data, rx is the line late in each high phase
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda_oe_o = ~tx[i]; // byte msb first, then the acknowledge bit
         #HALF_NS;
         scl_oe_o = 1'b0;
         wait (scl_i === 1'b1); // the device may stretch the low phase
         #HALF_NS;
         rx[i] = sda_i; // data stays put while the clock is high
         scl_oe_o = 1'b1;
      end
      sda_oe_o = 1'b0;
      #HALF_NS;
   endtask

   // stop: data rises while the clock is high
   task automatic stop_cond();
      sda_oe_o = 1'b1;
      #HALF_NS;
      scl_oe_o = 1'b0;
      wait (scl_i === 1'b1);
      #HALF_NS;
      sda_oe_o = 1'b0;
      #HALF_NS;
   endtask

   // ***************
   // slave behaviour
   // ***************
   // take eight bits on clock rises, then pull data low through the ninth clock
   task automatic slave_rx(output logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         @(posedge scl_i);
         d = {d[6:0], sda_i};
      end
      @(negedge scl_i);
      #10;
      sda_oe_o = 1'b1;
      @(negedge scl_i);
      #10;
      sda_oe_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// *** bench/smbus_byte_transfer_timing_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module smbus_byte_transfer_timing_bench;
   // ******************
   // signals and wiring
   // ******************
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic irq_o;
   logic scl_oe_o;
   logic sda_oe_o;
   logic scl_o;
   logic sda_o;
   logic peer_scl_oe;
   logic peer_sda_oe;
   logic scl_line;
   logic sda_line;
   int compares = 0;
   int miscompares = 0;
   logic [31:0] q;
   logic [8:0] r;
   logic [7:0] d;
   logic [7:0] r_adr [7] = '{smbbt_pkg::ADR_CTRL, smbbt_pkg::ADR_STAT, smbbt_pkg::ADR_SHIFT,
      smbbt_pkg::ADR_OWN, smbbt_pkg::ADR_ISTAT, smbbt_pkg::ADR_IMASK, 8'h1C};
   logic [7:0] r_exp [7] = '{smbbt_pkg::CTRL_RST, 8'h00, smbbt_pkg::SHIFT_RST,
      {1'b0, smbbt_pkg::OWN_RST}, 8'h00, 8'h00, 8'h00};

   // pulled-up wires: low while any party pulls
   assign scl_line = ~(scl_oe_o | peer_scl_oe);
   assign sda_line = ~(sda_oe_o | peer_sda_oe);

   // 125 MHz system clock
   always #4 clk_i = ~clk_i;

   // design and far-side peer
   smbbt_core #(.HALF_CYC(8)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .irq_o(irq_o),
      .scl_i(scl_line), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o)
   );
   smbbt_peer peer_u (
      .scl_i(scl_line), .sda_i(sda_line), .scl_oe_o(peer_scl_oe), .sda_oe_o(peer_sda_oe)
   );

   // *****
   // tasks
   // *****
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic chk1(input string what, input logic seen, input logic exp);
      check(what, {31'h0, seen}, {31'h0, exp});
   endtask

   task automatic final_report();
      if (miscompares == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // one classic wishbone cycle, held until ack is sampled high
   task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h00_0000, v};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      chk1("wb_ack_o", wb_ack_o, 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      wb_xfer(a, 1'b1, v);
   endtask

   task automatic rd(input logic [7:0] a);
      wb_xfer(a, 1'b0, 8'h00);
   endtask

   // read status and compare one bit of it
   task automatic stat(input string what, input int b, input logic exp);
      rd(smbbt_pkg::ADR_STAT);
      chk1(what, q[b], exp);
   endtask

   // ********
   // watchdog
   // ********
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      final_report();
   end

   // *****
   // tests
   // *****
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, read-only status, unmapped place, write with lane 0 off
      for (int i = 0; i < 7; i++) begin
         rd(r_adr[i]);
         check("reset value", q, {24'h00_0000, r_exp[i]});
      end
      wr(smbbt_pkg::ADR_STAT, 8'hFF);
      rd(smbbt_pkg::ADR_STAT);
      check("status after write", q, 32'h0000_0000);
      wb_sel_i <= 4'hE;
      wr(smbbt_pkg::ADR_OWN, 8'h22);
      wb_sel_i <= 4'hF;
      rd(smbbt_pkg::ADR_OWN);
      check("own address", q, 32'h0000_0010);
      // slave receive, all events enabled, wait after the ninth clock
      wr(smbbt_pkg::ADR_IMASK, 8'h07);
      wr(smbbt_pkg::ADR_CTRL, 8'h78);
      peer_u.start_cond();
      tick(2);
      rd(smbbt_pkg::ADR_ISTAT);
      check("start event", q, 32'h0000_0001);
      chk1("irq on start", irq_o, 1'b1);
      wr(smbbt_pkg::ADR_IMASK, 8'h00);
      tick(2);
      chk1("irq masked", irq_o, 1'b0);
      wr(smbbt_pkg::ADR_IMASK, 8'h07);
      wr(smbbt_pkg::ADR_ISTAT, 8'h01);
      tick(2);
      chk1("irq cleared", irq_o, 1'b0);
      peer_u.xfer({8'h20, 1'b1}, r);
      chk1("own address ack", r[0], 1'b0);
      tick(4);
      stat("waiting", smbbt_pkg::S_WAIT, 1'b1);
      stat("direction receive", smbbt_pkg::S_TRC, 1'b0);
      chk1("clock held", scl_oe_o, 1'b1);
      rd(smbbt_pkg::ADR_ISTAT);
      check("transfer event", q, 32'h0000_0002);
      wr(smbbt_pkg::ADR_ISTAT, 8'h02);
      wr(smbbt_pkg::ADR_SHIFT, 8'hFF);
      tick(2);
      chk1("clock freed by shift", scl_oe_o, 1'b0);
      peer_u.xfer({8'hA5, 1'b1}, r);
      tick(4);
      rd(smbbt_pkg::ADR_SHIFT);
      check("received byte", q, 32'h0000_00A5);
      wr(smbbt_pkg::ADR_CTRL, 8'h7C);
      tick(2);
      chk1("clock freed by release", scl_oe_o, 1'b0);
      peer_u.stop_cond();
      tick(8);
      rd(smbbt_pkg::ADR_ISTAT);
      check("stop event", q, 32'h0000_0006);
      // events disabled, foreign address refused
      wr(smbbt_pkg::ADR_ISTAT, 8'h07);
      wr(smbbt_pkg::ADR_CTRL, 8'h48);
      peer_u.start_cond();
      peer_u.xfer({8'h44, 1'b1}, r);
      chk1("foreign address ack", r[0], 1'b1);
      tick(4);
      chk1("no wait on foreign", scl_oe_o, 1'b0);
      peer_u.stop_cond();
      tick(8);
      rd(smbbt_pkg::ADR_ISTAT);
      check("events disabled", q, 32'h0000_0000);
      // extension code
      peer_u.start_cond();
      peer_u.xfer({8'hF0, 1'b1}, r);
      tick(4);
      stat("extension flag", smbbt_pkg::S_EXC, 1'b1);
      rd(smbbt_pkg::ADR_ISTAT);
      check("extension event", q, 32'h0000_0002);
      wr(smbbt_pkg::ADR_CTRL, 8'h4C);
      peer_u.stop_cond();
      // slave transmit
      tick(8);
      wr(smbbt_pkg::ADR_ISTAT, 8'h07);
      peer_u.start_cond();
      peer_u.xfer({8'h21, 1'b1}, r);
      tick(4);
      stat("direction send", smbbt_pkg::S_TRC, 1'b1);
      wr(smbbt_pkg::ADR_SHIFT, 8'h3C);
      peer_u.xfer({8'hFF, 1'b1}, r);
      check("sent byte", {24'h00_0000, r[8:1]}, 32'h0000_003C);
      tick(4);
      wr(smbbt_pkg::ADR_CTRL, 8'h4C);
      peer_u.stop_cond();
      // master address with read direction
      tick(8);
      fork
         peer_u.slave_rx(d);
         begin
            wr(smbbt_pkg::ADR_CTRL, 8'hC9);
            tick(20);
            wr(smbbt_pkg::ADR_SHIFT, 8'h5A);
         end
      join
      check("address on wire", {24'h00_0000, d}, 32'h0000_005B);
      tick(8);
      stat("master", smbbt_pkg::S_MST, 1'b1);
      stat("ack detected", smbbt_pkg::S_ACKD, 1'b1);
      stat("master waits", smbbt_pkg::S_WAIT, 1'b1);
      wr(smbbt_pkg::ADR_CTRL, 8'h4A);
      tick(40);
      stat("master done", smbbt_pkg::S_MST, 1'b0);
      stat("bus free", smbbt_pkg::S_BUSY, 1'b0);
      chk1("open drain levels", scl_o | sda_o, 1'b0);
      final_report();
   end
endmodule
`default_nettype wire
